// ---- src/ssm_pkg.sv ----
// constants for the spread spectrum profile generator
// assumes a single clock running at the phase detector rate
package ssm_pkg;
    // ------------------------------------------------------------
    // field widths
    // ------------------------------------------------------------
    localparam int STEP_W = 4;
    localparam int NCNT_W = 3;
    localparam int OFS_W = 6;
    localparam int DELTA_W = 4;
    localparam int NUM_DELTA = 12;
    localparam int ACC_W = 8;
    localparam int OUT_W = 9;
    localparam int REFDIV_W = 8;
    localparam int FBCNT_W = 16;
    // ------------------------------------------------------------
    // equation constants
    // ------------------------------------------------------------
    localparam logic [STEP_W:0] STEP_ADD = 5'h02;
    localparam logic [STEP_W-1:0] STEP_OFF = 4'h0;
    localparam int NCNT_MUL_SH = 1;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
    typedef enum logic [1:0] {
        SSM_Q_RISE,
        SSM_Q_FALL,
        SSM_Q_NRISE,
        SSM_Q_NFALL
    } ssm_quad_e;
endpackage

// ---- src/ssm_top.sv ----
// spread spectrum profile generator for the fractional feedback divider
// assumes configuration inputs are static, from the same clock domain
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ssm_top (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // first pll profile configuration
    input wire logic [ssm_pkg::STEP_W-1:0] i_step_period,
    input wire logic [ssm_pkg::NCNT_W-1:0] i_sample_count,
    input wire logic [ssm_pkg::OFS_W-1:0] i_frac_offset,
    input wire logic [ssm_pkg::NUM_DELTA*ssm_pkg::DELTA_W-1:0]
        i_profile_delta_sample,
    input wire logic i_lsb_dither_en,
    input wire logic i_double_amplitude_en,
    // fourth pll spread configuration
    input wire logic i_pll3_spread_en,
    input wire logic [ssm_pkg::REFDIV_W-1:0] i_pll3_spread_ref_div,
    input wire logic [ssm_pkg::FBCNT_W-1:0] i_pll3_spread_fb_count,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // first pll divider side
    output logic o_spread_active,
    output logic [ssm_pkg::OUT_W-1:0] o_frac_value,
    output logic o_step_strobe,
    // fourth pll divider side
    output logic o_pll3_spread_active,
    output logic [ssm_pkg::REFDIV_W-1:0] o_pll3_ref_div,
    output logic [ssm_pkg::FBCNT_W-1:0] o_pll3_fb_count
);
    import ssm_pkg::*;

    // ------------------------------------------------------------
    // register port: status read, soft hold control
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h1;
    logic hold_r;
    logic [31:0] rdata_r;
    wire wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
    wire [31:0] stat_word;
    wire [31:0] rd_mux;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            hold_r <= 1'b0;
        end else if (wr_ctrl) begin
            hold_r <= i_wdata[0];
        end
    end

    // ------------------------------------------------------------
    // enables
    // ------------------------------------------------------------
    wire spread_en = (i_step_period != STEP_OFF) && !hold_r;
    assign o_pll3_spread_active = i_pll3_spread_en;
    // spread divider values only steer the loop while enabled
    assign o_pll3_ref_div = i_pll3_spread_en ? i_pll3_spread_ref_div
                                             : '0;
    assign o_pll3_fb_count = i_pll3_spread_en ? i_pll3_spread_fb_count
                                              : '0;

    // ------------------------------------------------------------
    // step timing and sample index
    // ------------------------------------------------------------
    logic [STEP_W:0] step_cnt_r;
    logic [3:0] idx_r;
    ssm_quad_e quad_r;
    logic [ACC_W-1:0] acc_r;
    logic [OUT_W-1:0] frac_r;
    logic [15:0] lfsr_r;
    logic en_d_r;

    wire [STEP_W:0] step_len = {1'b0, i_step_period} + STEP_ADD;
    wire step_end = (step_cnt_r == step_len - 5'h01);
    // count wraps are decoded from the registered index
    wire [3:0] n_eff = {i_sample_count, 1'b0};
    wire idx_last = (idx_r == n_eff - 4'h1);
    wire rising = (quad_r == SSM_Q_RISE) || (quad_r == SSM_Q_NRISE);
    wire negate = (quad_r == SSM_Q_NRISE) || (quad_r == SSM_Q_NFALL);
    wire [3:0] delta_idx = rising ? idx_r : (n_eff - 4'h1 - idx_r);
    wire [DELTA_W-1:0] cur_delta =
        i_profile_delta_sample[delta_idx*DELTA_W +: DELTA_W];
    wire [ACC_W-1:0] acc_up = acc_r + {4'h0, cur_delta};
    wire [ACC_W-1:0] acc_dn = acc_r - {4'h0, cur_delta};
    wire [ACC_W-1:0] acc_nxt = rising ? acc_up : acc_dn;
    ssm_quad_e quad_nxt;

    always_comb begin
        unique case (quad_r)
            SSM_Q_RISE: quad_nxt = SSM_Q_FALL;
            SSM_Q_FALL: quad_nxt = SSM_Q_NRISE;
            SSM_Q_NRISE: quad_nxt = SSM_Q_NFALL;
            SSM_Q_NFALL: quad_nxt = SSM_Q_RISE;
        endcase
    end

    // held in reset while disabled so enabling restarts cleanly
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            step_cnt_r <= '0;
            idx_r <= '0;
            quad_r <= SSM_Q_RISE;
            acc_r <= '0;
        end else if (!spread_en) begin
            step_cnt_r <= '0;
            idx_r <= '0;
            quad_r <= SSM_Q_RISE;
            acc_r <= '0;
        end else if (step_end) begin
            step_cnt_r <= '0;
            acc_r <= acc_nxt;
            if (idx_last) begin
                idx_r <= '0;
                quad_r <= quad_nxt;
            end else begin
                idx_r <= idx_r + 4'h1;
            end
        end else begin
            step_cnt_r <= step_cnt_r + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // output value: offset plus signed, scaled, dithered amplitude
    // ------------------------------------------------------------
    // a step end shows the new sum at once, so the first value never repeats
    wire [ACC_W-1:0] acc_sel = step_end ? acc_nxt : acc_r;
    wire [OUT_W-1:0] amp = i_double_amplitude_en ?
        {acc_sel, 1'b0} : {1'b0, acc_sel};
    wire [OUT_W-1:0] amp_d = {amp[OUT_W-1:1],
        amp[0] ^ (i_lsb_dither_en & lfsr_r[0])};
    // zero offset centres on nominal; nonzero shifts the centre up
    wire [OUT_W-1:0] base = {3'h0, i_frac_offset};
    wire [OUT_W-1:0] frac_nxt = negate ? (base - amp_d)
                                       : (base + amp_d);

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            lfsr_r <= LFSR_SEED;
        end else if (step_end) begin
            lfsr_r <= lfsr_r[0] ? ((lfsr_r >> 1) ^ LFSR_TAPS) : (lfsr_r >> 1);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            frac_r <= '0;
            en_d_r <= 1'b0;
        end else begin
            en_d_r <= spread_en;
            if (!spread_en) begin
                frac_r <= base;
            end else if (step_end || !en_d_r) begin
                frac_r <= frac_nxt;
            end
        end
    end

    assign o_frac_value = frac_r;
    assign o_spread_active = en_d_r;
    assign o_step_strobe = spread_en && step_end;

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    assign stat_word = {16'h0000, acc_r, 2'h0, quad_r, idx_r};
    assign rd_mux = (i_addr == ADDR_CTRL) ? {31'h0, hold_r} :
                    (i_addr == ADDR_STAT) ? stat_word : 32'h0;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= i_rd ? rd_mux : 32'h0;
        end
    end
    assign o_rdata = rdata_r;

    // ------------------------------------------------------------
    // checks: step timing and sequencing
    // ------------------------------------------------------------
    step_len_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        o_step_strobe && $stable(i_step_period) |=> !o_step_strobe [*1])
        else $error("step strobe repeated");

    cnt_range_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        spread_en |-> step_cnt_r < step_len)
        else $error("step counter past period");

    cnt_adv_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        spread_en && !step_end |=> step_cnt_r == $past(step_cnt_r) + 5'h01)
        else $error("step counter stalled");

    strobe_rst_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        o_step_strobe |=> step_cnt_r == 5'h00)
        else $error("step counter not restarted");

    disable_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (i_step_period == STEP_OFF) |=> (idx_r == 4'h0) && !o_step_strobe)
        else $error("spread not held off");

    restart_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        $rose(spread_en) |-> quad_r == SSM_Q_RISE && acc_r == 8'h00)
        else $error("profile did not restart");

    active_dly_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        1'b1 |=> o_spread_active == $past(spread_en))
        else $error("active flag wrong");

    idx_range_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        spread_en && i_sample_count != 3'h0 |-> idx_r < n_eff)
        else $error("index beyond count");

    idx_adv_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        spread_en && step_end && !idx_last |=> idx_r == $past(idx_r) + 4'h1)
        else $error("index not advanced");

    quad_adv_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        spread_en && step_end && idx_last && $stable(i_sample_count)
        |=> quad_r != $past(quad_r))
        else $error("quadrant not advanced");

    quad_keep_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        spread_en && !(step_end && idx_last) |=> quad_r == $past(quad_r))
        else $error("quadrant moved early");

    acc_zero_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        spread_en && step_end && idx_last && !rising |=> acc_r == 8'h00)
        else $error("mirror did not return to zero");

    // ------------------------------------------------------------
    // checks: profile value
    // ------------------------------------------------------------
    hold_frac_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        en_d_r && $past(en_d_r) && spread_en && !$past(step_end)
        |-> $stable(o_frac_value))
        else $error("value changed mid step");

    frac_start_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !en_d_r && spread_en && !i_lsb_dither_en |=> o_frac_value == $past(base))
        else $error("profile did not start at offset");

    pos_step_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        spread_en && step_end && !negate && !i_lsb_dither_en &&
        !i_double_amplitude_en
        |=> o_frac_value == $past(base) + {1'b0, $past(acc_nxt)})
        else $error("positive step value wrong");

    neg_step_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        spread_en && step_end && negate && !i_lsb_dither_en &&
        !i_double_amplitude_en
        |=> o_frac_value == $past(base) - {1'b0, $past(acc_nxt)})
        else $error("negative step value wrong");

    off_frac_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !spread_en |=> o_frac_value == $past(base))
        else $error("offset not shown while off");

    x2_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_double_amplitude_en |-> amp == {acc_sel, 1'b0})
        else $error("amplitude not doubled");

    x1_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !i_double_amplitude_en |-> amp == {1'b0, acc_sel})
        else $error("amplitude not nominal");

    dither_off_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !i_lsb_dither_en |-> amp_d == amp)
        else $error("lsb changed without dither");

    lfsr_hold_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !step_end |=> $stable(lfsr_r))
        else $error("dither source moved mid step");

    // ------------------------------------------------------------
    // checks: fourth pll
    // ------------------------------------------------------------
    pll3_en_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !i_pll3_spread_en |-> o_pll3_fb_count == 16'h0000 &&
        o_pll3_ref_div == 8'h00)
        else $error("fourth pll values leak");

    pll3_on_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_pll3_spread_en |-> o_pll3_ref_div == i_pll3_spread_ref_div)
        else $error("fourth pll divider not passed");

    pll3_fb_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_pll3_spread_en |-> o_pll3_fb_count == i_pll3_spread_fb_count)
        else $error("fourth pll count not passed");

    // ------------------------------------------------------------
    // checks: register port
    // ------------------------------------------------------------
    rd_data_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_rd && i_addr == ADDR_CTRL |=> o_rdata == {31'h0, $past(hold_r)})
        else $error("bad control read");

    stat_rd_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_rd && i_addr == ADDR_STAT |=> o_rdata == $past(stat_word))
        else $error("bad status read");

    rd_idle_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !i_rd |=> o_rdata == 32'h0)
        else $error("read data without strobe");

    hold_wr_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        wr_ctrl |=> hold_r == $past(i_wdata[0]))
        else $error("hold write lost");
endmodule
`default_nettype wire

// ---- dv/ssm_fb_model.sv ----
// feedback divider model: watches the profile it is fed
// assumes the bench clears it before each measured run
`timescale 1ns/1ps
`default_nettype none
module ssm_fb_model (
    // clock and control
    input wire logic i_clk_sys,
    input wire logic i_clear,
    // profile from the generator
    input wire logic i_spread_active,
    input wire logic [ssm_pkg::OUT_W-1:0] i_frac_value,
    input wire logic i_step_strobe,
    // observations
    output logic [ssm_pkg::OUT_W-1:0] o_max,
    output logic [ssm_pkg::OUT_W-1:0] o_min,
    output logic [15:0] o_steps,
    output logic [15:0] o_jumps
);
    import ssm_pkg::*;
    logic [OUT_W-1:0] last_r;
    logic strb_r;
    logic act_r;
    always @(posedge i_clk_sys) begin
        if (i_clear) begin
            o_max <= '0;
            o_min <= '1;
            o_steps <= '0;
            o_jumps <= '0;
        end else if (i_spread_active) begin
            if (i_frac_value > o_max) o_max <= i_frac_value;
            if (i_frac_value < o_min) o_min <= i_frac_value;
            if (i_step_strobe) o_steps <= o_steps + 16'h1;
            // value may only move right after a strobe
            if (act_r && !strb_r && i_frac_value != last_r)
                o_jumps <= o_jumps + 16'h1;
        end
        last_r <= i_frac_value;
        strb_r <= i_step_strobe;
        act_r <= i_spread_active;
    end
endmodule
`default_nettype wire

// ---- dv/ssm_top_tb_top.sv ----
// self-checking bench for the spread profile generator
// assumes the design settles outputs within 1 ns of an edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
 $display("ERROR %0t got %h exp %h", $time, a, b); end end
module ssm_top_tb_top;
    import ssm_pkg::*;
    logic clk = 0, nrst = 0, clr = 0, lsb_dither_en = 0, x2 = 0, wr = 0, rd = 0;
    logic [3:0] step = 0, addr = 0;
    logic [2:0] cnt = 0;
    logic [5:0] ofs = 0;
    logic [31:0] wdata = 0, rdata;
    logic p3en = 0, act, strb, p3act;
    logic [7:0] p3div = 0, p3div_o;
    logic [15:0] p3fb = 0, p3fb_o, steps, jumps;
    logic [8:0] frac, fmax, fmin;
    int mismatches = 0, compares = 0;
    always #2.5 clk = ~clk;
    ssm_top i_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_step_period(step),
        .i_sample_count(cnt), .i_frac_offset(ofs),
        .i_profile_delta_sample(48'h333333333333), .i_lsb_dither_en(lsb_dither_en),
        .i_double_amplitude_en(x2), .i_pll3_spread_en(p3en),
        .i_pll3_spread_ref_div(p3div), .i_pll3_spread_fb_count(p3fb),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_spread_active(act), .o_frac_value(frac),
        .o_step_strobe(strb), .o_pll3_spread_active(p3act),
        .o_pll3_ref_div(p3div_o), .o_pll3_fb_count(p3fb_o));
    ssm_fb_model i_fb (.i_clk_sys(clk), .i_clear(clr),
        .i_spread_active(act), .i_frac_value(frac), .i_step_strobe(strb),
        .o_max(fmax), .o_min(fmin), .o_steps(steps), .o_jumps(jumps));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // deltas 3+3 with offset 0x14 keep the sum legal and never all zero
    task automatic cfg(input logic [3:0] f, input logic [5:0] o,
        input logic a, input logic d);
        @(posedge clk);
        step <= f;
        cnt <= 3'h1;
        ofs <= o;
        x2 <= a;
        lsb_dither_en <= d;
        clr <= (f == 4'h0);
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= w; rd <= !w;
        @(posedge clk);
        wr <= 0; rd <= 0;
        #1;
        if (!w) `CHK(rdata, d)
    endtask
    task automatic wait_strb;
        int n;
        for (n = 0; n < 40 && strb !== 1'b1; n++) tick(1);
    endtask
    task automatic t_step(input logic [3:0] f, input logic a,
        input logic d);
        int n;
        logic [8:0] e;
        e = 9'h014 + (a ? 9'h006 : 9'h003);
        cfg(4'h0, 6'h14, 0, 0);
        tick(3);
        cfg(f, 6'h14, a, d);
        tick(1);
        `CHK(act, 1'b1)
        `CHK(frac | d, 9'h014 | d)
        wait_strb();
        tick(1);
        `CHK(frac | d, e | d)
        for (n = 1; n < 40 && strb !== 1'b1; n++) tick(1);
        `CHK(n, f + 2)
    endtask
    task automatic t_period;
        int n;
        cfg(4'h0, 6'h14, 0, 0);
        tick(3);
        cfg(4'h5, 6'h14, 0, 0);
        for (n = 0; n < 200 && steps !== 16'h8; n++) tick(1);
        `CHK(n, 56)
        `CHK(frac, 9'h014)
        `CHK(fmax, 9'h01A)
        `CHK(fmin, 9'h00E)
        `CHK(jumps, 16'h0)
    endtask
    task automatic t_off;
        cfg(4'h0, 6'h00, 0, 0);
        tick(10);
        `CHK(act, 1'b0)
        `CHK(frac, 9'h000)
        `CHK(strb, 1'b0)
    endtask
    task automatic t_regs;
        cfg(4'h5, 6'h14, 0, 0);
        bus(1, 4'h0, 32'h1);
        tick(1);
        `CHK(act, 1'b0)
        `CHK(frac, 9'h014)
        bus(0, 4'h0, 32'h1);
        bus(0, 4'h1, 32'h0);
        bus(0, 4'hF, 32'h0);
        bus(1, 4'h0, 32'h0);
    endtask
    task automatic t_pll3;
        @(posedge clk);
        p3div <= 8'h5A; p3fb <= 16'hBEEF; p3en <= 0;
        tick(1);
        `CHK(p3act, 1'b0)
        `CHK(p3div_o, 8'h00)
        `CHK(p3fb_o, 16'h0000)
        @(posedge clk);
        p3en <= 1;
        tick(1);
        `CHK(p3act, 1'b1)
        `CHK(p3div_o, 8'h5A)
        `CHK(p3fb_o, 16'hBEEF)
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1;
        t_off();
        t_step(4'h5, 0, 0);
        t_step(4'hE, 1, 0);
        t_step(4'h5, 0, 1);
        t_period();
        t_regs();
        t_pll3();
        complete_run();
    end
    // hang guard: the whole sequence needs well under 1000 cycles
    initial begin
        #20000;
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
